// file: common/led_ctl_regs.vh
// register map, field positions and timing constants of the led control bank
`ifndef LED_CTL_REGS_VH
`define LED_CTL_REGS_VH
`define ADDR_MODE_CTL 8'h00
`define ADDR_ENABLE_HI 8'h01
`define ADDR_ENABLE_LO 8'h02
`define ADDR_LIGHTING_EFFECT 8'h03
`define ADDR_CHANNEL_FUNCTION_SELECT 8'h04
`define ADDR_GPIO_DIRECTION 8'h05
`define ADDR_GPIO_OUTPUT_LEVEL 8'h06
`define ADDR_GPIO_IRQ_MASK 8'h07
`define ADDR_GPIO_INPUT_STATE 8'h08
`define ADDR_SAMPLE_RATE_DIVISOR 8'h09
`define ADDR_DUTY_FIRST 8'h10
`define ADDR_DUTY_LAST 8'h1F
`define ADDR_FRAME_FIRST 8'h20
`define ADDR_FRAME_LAST 8'hAF
`define ADDR_DUTY_APPLY_STROBE 8'hB0
`define ADDR_FRAME_INTERVAL 8'hB6
`define ADDR_FIRST_FRAME_SELECT 8'hB7
`define FRAME_BYTES 8'd18
`define FRAME_COUNT_LAST 3'h7
`define APPLY_VALUE 8'h00
`define MODE_CTL_RESET 8'h80
`define ENABLE_RESET 8'hFF
`define MODE_MSB 6
`define MODE_LSB 5
`define MODE_DIRECT 2'h0
`define MODE_AUTO 2'h1
`define MODE_AUDIO 2'h2
`define CS_MSB 6
`define CS_LSB 4
`define CODE_MSB 7
`define CODE_LSB 5
`define DUTY_INDEX_TOP 4'hF
`define FRAME_DUTY_TOP 5'h11
`define FRAME_ON_HI_BYTE 5'h00
`define FRAME_ON_LO_BYTE 5'h01
`define AUDIO_FRAME_MSB 7
`define AUDIO_FRAME_LSB 5
`define CLOCK_HZ 40000000
`define BASE_DELAY_MS 32
`define BASE_DELAY_CYCLES (`CLOCK_HZ / 1000 * `BASE_DELAY_MS)
`define SAMPLE_BASE_HZ 15625
`define SAMPLE_TICK_CYCLES (`CLOCK_HZ / `SAMPLE_BASE_HZ)
`endif

// file: src/frame_ram.v
// frame animation memory, 144 bytes, registered read
`timescale 1ns/1ps
module frame_ram (
  input wire clock,
  input wire writeEnable,
  input wire [7:0] writeAddr,
  input wire [7:0] writeData,
  input wire [7:0] readAddr,
  output reg [7:0] readData
);
  reg [7:0] mem [0:143];
  always @(posedge clock) begin
    if (writeEnable) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule // frame_ram

// file: src/pin_sync.v
// three-stage synchroniser with agreement qualifier
`timescale 1ns/1ps
module pin_sync (
  input wire clock,
  input wire reset,
  input wire pinIn,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clock) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      // only s2 and s3 are compared, s1 may be metastable
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // pin_sync

// file: src/led_driver_control_registers.v
// register bank and playback control of the sixteen channel led driver
`timescale 1ns/1ps
`include "led_ctl_regs.vh"
// Overview of operation
// (RQ1) current-select code scales reference: 1.0,0.75,0.5,0.25,2.0,1.75,1.5,1.25.
// (RQ2) function bit 1 makes upper channel GPIO, 0 LED; GPIO ignores current.
// (RQ3) direction bit 0 output, 1 input; cleared at reset.
// (RQ4) GPIO output pin follows its output-level bit.
// (RQ5) mask bit 0 enables change detection, 1 disables; all enabled at reset.
// (RQ6) input pin levels captured into readable input state register.
// (RQ7) interrupt stays low until host reads input state; read releases it.
// (RQ8) audio sample rate is 15.625 kHz divided by sample-rate value.
// (RQ9) duty value sets current as full scale times value over 256.
// (RQ10) duty registers 10h-1Fh, lowest address drives highest channel.
// (RQ11) eight 18-byte frames at 20h-AFh: two on/off bytes, sixteen duty bytes.
// (RQ12) duty writes held in shadow until zero written to B0h.
// (RQ13) auto play frame delay doubles from 32 ms to 4.096 s by code.
// (RQ14) start-frame code 000..111 selects frame 1..8.
// (RQ15) auto play runs start frame to frame 8, then wraps to frame 1.
// (RQ16) mode 00 drives channels directly from applied duty registers.
// (RQ17) mode 00 direct, 01 auto play, 10 audio frames, 11 unavailable.
// (RQ18) audio magnitude maps smallest to frame 1, largest to frame 8.
// (RQ19) change on enabled upper input asserts interrupt low.
// (RQ20) on/off bit 0 turns channel off, 1 on.
// (RQ21) sample-rate value zero halts sampling.
// (RQ22) nonzero writes to update register are ignored.
module led_driver_control_registers (
  input wire clock,
  input wire reset,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  input wire [7:0] audioLevel,
  output reg audioSample,
  input wire [7:0] upperPinIn,
  output wire [7:0] upperPinOut,
  output wire [7:0] upperPinOe,
  output reg [127:0] channelDuty,
  output reg [15:0] channelOn,
  output reg [15:0] channelSinkEn,
  output reg [3:0] currentScaleQ2,
  output reg irq_n
);
  reg [7:0] modeCtl;
  reg [15:0] enableBits;
  reg [7:0] lightingEffect;
  reg [7:0] channelFunctionSelect;
  reg [7:0] gpioDirection;
  reg [7:0] gpioOutputLevel;
  reg [7:0] gpioIrqMask;
  reg [7:0] gpioInputState;
  reg [7:0] sampleRateDivisor;
  reg [7:0] frameInterval;
  reg [7:0] firstFrameSelect;
  reg [127:0] shadowDuty;
  reg [127:0] appliedDuty;
  wire [7:0] pinLevel;
  reg [7:0] pinPrev;
  wire [1:0] mode = modeCtl[`MODE_MSB:`MODE_LSB];

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : syncs
      pin_sync u_sync (
        .clock(clock),
        .reset(reset),
        .pinIn(upperPinIn[g]),
        .level(pinLevel[g])
      );
    end
  endgenerate

  // register writes; duty index: 1Fh is channel 1, 10h is channel 16
  wire dutyHit = regWrite && regAddr >= `ADDR_DUTY_FIRST && regAddr <= `ADDR_DUTY_LAST; // RQ10
  wire [3:0] dutyChan = `DUTY_INDEX_TOP - regAddr[3:0]; // RQ10
  wire frameHit = regWrite && regAddr >= `ADDR_FRAME_FIRST && regAddr <= `ADDR_FRAME_LAST; // RQ11
  wire [7:0] frameWrAddr = regAddr - `ADDR_FRAME_FIRST; // RQ11
  wire applyHit = regWrite && regAddr == `ADDR_DUTY_APPLY_STROBE && regWriteData == `APPLY_VALUE; // RQ12 RQ22
  always @(posedge clock) begin
    if (reset) begin
      modeCtl <= `MODE_CTL_RESET;
      enableBits <= {2{`ENABLE_RESET}};
      lightingEffect <= 8'h00;
      channelFunctionSelect <= 8'h00;
      gpioDirection <= 8'h00; // RQ3
      gpioOutputLevel <= 8'h00;
      gpioIrqMask <= 8'h00; // RQ5
      sampleRateDivisor <= 8'h00;
      frameInterval <= 8'h00;
      firstFrameSelect <= 8'h00;
      shadowDuty <= 128'h0;
      appliedDuty <= 128'h0;
    end else begin
      if (regWrite) begin
        case (regAddr)
          `ADDR_MODE_CTL: modeCtl <= regWriteData;
          `ADDR_ENABLE_HI: enableBits[15:8] <= regWriteData;
          `ADDR_ENABLE_LO: enableBits[7:0] <= regWriteData;
          `ADDR_LIGHTING_EFFECT: lightingEffect <= regWriteData;
          `ADDR_CHANNEL_FUNCTION_SELECT: channelFunctionSelect <= regWriteData;
          `ADDR_GPIO_DIRECTION: gpioDirection <= regWriteData;
          `ADDR_GPIO_OUTPUT_LEVEL: gpioOutputLevel <= regWriteData;
          `ADDR_GPIO_IRQ_MASK: gpioIrqMask <= regWriteData;
          `ADDR_SAMPLE_RATE_DIVISOR: sampleRateDivisor <= regWriteData;
          `ADDR_FRAME_INTERVAL: frameInterval <= regWriteData;
          `ADDR_FIRST_FRAME_SELECT: firstFrameSelect <= regWriteData;
          default: ;
        endcase
      end
      if (dutyHit) begin
        shadowDuty[dutyChan*8 +: 8] <= regWriteData; // RQ12
      end
      // the write in the apply cycle is not yet in the shadow; it waits for the next strobe
      if (applyHit) begin
        appliedDuty <= shadowDuty; // RQ12
      end
    end
  end

  // gpio pins: driven only when GPIO and output direction
  assign upperPinOe = channelFunctionSelect & ~gpioDirection; // RQ2 RQ3
  assign upperPinOut = gpioOutputLevel; // RQ4

  // input capture and change interrupt
  wire [7:0] inputMask = channelFunctionSelect & gpioDirection;
  wire [7:0] changed = (pinLevel ^ pinPrev) & inputMask & ~gpioIrqMask; // RQ5 RQ19
  wire stateRead = regRead && regAddr == `ADDR_GPIO_INPUT_STATE;
  always @(posedge clock) begin
    if (reset) begin
      pinPrev <= 8'h00;
      gpioInputState <= 8'h00;
      irq_n <= 1'b1;
      regReadData <= 8'h00;
    end else begin
      pinPrev <= pinLevel;
      gpioInputState <= pinLevel & inputMask; // RQ6
      // a change in the read cycle wins over the release
      if (|changed) begin
        irq_n <= 1'b0; // RQ19
      end else if (stateRead) begin
        irq_n <= 1'b1; // RQ7
      end
      if (stateRead) begin
        regReadData <= gpioInputState; // RQ6
      end else if (regRead) begin
        regReadData <= 8'h00;
      end
    end
  end

  // audio sample tick: base 15.625 kHz divided by the sample-rate value
  reg [11:0] baseCount;
  reg [7:0] divCount;
  wire baseTick = baseCount == `SAMPLE_TICK_CYCLES - 1;
  reg [7:0] audioHeld;
  always @(posedge clock) begin
    if (reset) begin
      baseCount <= 12'h000;
      divCount <= 8'h00;
      audioSample <= 1'b0;
      audioHeld <= 8'h00;
    end else begin
      audioSample <= 1'b0;
      baseCount <= baseTick ? 12'h000 : baseCount + 12'h001;
      if (mode != `MODE_AUDIO || sampleRateDivisor == 8'h00) begin
        divCount <= 8'h00; // RQ21
      end else if (baseTick) begin
        if (divCount >= sampleRateDivisor - 8'h01) begin
          divCount <= 8'h00;
          audioSample <= 1'b1; // RQ8
          audioHeld <= audioLevel;
        end else begin
          divCount <= divCount + 8'h01;
        end
      end
    end
  end

  // auto play frame timer; delay = 32 ms shifted left by code
  reg [31:0] delayCount;
  reg [2:0] autoFrame;
  reg [1:0] modePrev;
  wire [2:0] delayCode = frameInterval[`CODE_MSB:`CODE_LSB];
  wire [31:0] delayLimit = (`BASE_DELAY_CYCLES << delayCode) - 1; // RQ13
  always @(posedge clock) begin
    if (reset) begin
      delayCount <= 32'h0;
      autoFrame <= 3'h0;
      modePrev <= `MODE_DIRECT;
    end else begin
      modePrev <= mode;
      if (mode == `MODE_AUTO && modePrev != `MODE_AUTO) begin
        autoFrame <= firstFrameSelect[`CODE_MSB:`CODE_LSB]; // RQ14
        delayCount <= 32'h0;
      end else if (mode == `MODE_AUTO) begin
        if (delayCount >= delayLimit) begin
          delayCount <= 32'h0;
          // 3-bit counter wraps frame 8 to frame 1
          autoFrame <= autoFrame + 3'h1; // RQ15
        end else begin
          delayCount <= delayCount + 32'h1;
        end
      end
    end
  end

  // audio magnitude to frame: top three bits of sample
  wire [2:0] audioFrame = audioHeld[`AUDIO_FRAME_MSB:`AUDIO_FRAME_LSB]; // RQ18
  wire [2:0] showFrame = (mode == `MODE_AUTO) ? autoFrame : audioFrame;
  wire frameMode = (mode == `MODE_AUTO) || (mode == `MODE_AUDIO); // RQ17

  // frame fetch: walk the 18 bytes of the shown frame, one per cycle
  reg [4:0] fetchIdx;
  reg [4:0] fetchIdxD;
  reg [127:0] frameDuty;
  reg [15:0] frameOn;
  wire [7:0] frameRdAddr = showFrame * `FRAME_BYTES + {3'h0, fetchIdx}; // RQ11
  wire [7:0] frameRdData;
  frame_ram u_ram (
    .clock(clock),
    .writeEnable(frameHit),
    .writeAddr(frameWrAddr),
    .writeData(regWriteData),
    .readAddr(frameRdAddr),
    .readData(frameRdData)
  );
  always @(posedge clock) begin
    if (reset) begin
      fetchIdx <= 5'h00;
      fetchIdxD <= 5'h00;
      frameDuty <= 128'h0;
      frameOn <= 16'h0;
    end else begin
      fetchIdx <= (fetchIdx == `FRAME_BYTES - 1) ? 5'h00 : fetchIdx + 5'h01;
      fetchIdxD <= fetchIdx;
      // byte 0 holds channels 9..16, byte 1 channels 1..8, then duty bytes channel 16 down to 1
      if (fetchIdxD == `FRAME_ON_HI_BYTE) begin
        frameOn[15:8] <= frameRdData;
      end else if (fetchIdxD == `FRAME_ON_LO_BYTE) begin
        frameOn[7:0] <= frameRdData;
      end else begin
        frameDuty[(`FRAME_DUTY_TOP - fetchIdxD) * 8 +: 8] <= frameRdData; // RQ11
      end
    end
  end

  // output stage
  reg [3:0] next_scale;
  always @* begin
    case (lightingEffect[`CS_MSB:`CS_LSB]) // RQ1
      3'h0: next_scale = 4'h4;
      3'h1: next_scale = 4'h3;
      3'h2: next_scale = 4'h2;
      3'h3: next_scale = 4'h1;
      3'h4: next_scale = 4'h8;
      3'h5: next_scale = 4'h7;
      3'h6: next_scale = 4'h6;
      3'h7: next_scale = 4'h5;
      default: next_scale = 4'h4;
    endcase
  end
  always @(posedge clock) begin
    if (reset) begin
      channelDuty <= 128'h0;
      channelOn <= 16'h0;
      channelSinkEn <= 16'h0;
      currentScaleQ2 <= 4'h4;
    end else begin
      currentScaleQ2 <= next_scale; // RQ1
      // duty drives average current as full scale times value over 256
      channelDuty <= frameMode ? frameDuty : appliedDuty; // RQ9 RQ16
      channelOn <= frameMode ? frameOn : enableBits; // RQ20
      channelSinkEn <= {~channelFunctionSelect, 8'hFF}; // RQ2
    end
  end
endmodule // led_driver_control_registers

// file: test/led_ctl_checker.sv
// port assertions for the led control bank
`timescale 1ns/1ps
module led_ctl_checker (
  input wire clock,
  input wire reset,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWriteData,
  input wire [7:0] regReadData,
  input wire audioSample,
  input wire [7:0] upperPinOut,
  input wire [7:0] upperPinOe,
  input wire [127:0] channelDuty,
  input wire [15:0] channelSinkEn,
  input wire [3:0] currentScaleQ2,
  input wire irq_n
);
  localparam [31:0] SCALES = 32'h56781234;
  reg [7:0] fnReg, dirReg, lvlReg, srReg;
  reg [3:0] expScale;
  reg [1:0] mode;
  wire applyHit = regWrite && regAddr == 8'hB0 && regWriteData == 8'h00;
  always @(posedge clock) begin
    if (reset) begin
      {fnReg, dirReg, lvlReg, srReg} <= 32'h00000000;
      expScale <= 4'h4;
      mode <= 2'h0;
    end else if (regWrite) begin
      case (regAddr)
        8'h00: mode <= regWriteData[6:5];
        8'h03: expScale <= SCALES[{regWriteData[6:4], 2'h0} +: 4];
        8'h04: fnReg <= regWriteData;
        8'h05: dirReg <= regWriteData;
        8'h06: lvlReg <= regWriteData;
        8'h09: srReg <= regWriteData;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence stateRead; regRead && regAddr == 8'h08; endsequence
  sequence scaleWrite; regWrite && regAddr == 8'h03; endsequence
  sequence funcWrite; regWrite && regAddr == 8'h04; endsequence
  readRelease_a: assert property (stateRead |=> irq_n)
    else $error("irq not released by state read");
  irqHold_a: assert property (!irq_n && !(regRead && regAddr == 8'h08) |=> !irq_n)
    else $error("irq released without state read");
  readZero_a: assert property (regRead && regAddr != 8'h08 |=> regReadData == 8'h00)
    else $error("non state read returned data");
  scaleMap_a: assert property (scaleWrite |-> ##2 currentScaleQ2 == $past(expScale))
    else $error("current scale wrong for code");
  sinkMask_a: assert property (funcWrite |-> ##2 channelSinkEn[15:8] == ~$past(fnReg))
    else $error("sink enable not following function select");
  pinEnable_a: assert property (upperPinOe == (fnReg & ~dirReg))
    else $error("pin drive enable wrong");
  pinLevel_a: assert property (upperPinOut == lvlReg)
    else $error("pin output level wrong");
  // a shadow write alone must never move the outputs in direct mode
  dutyApply_a: assert property (mode == 2'h0 && $changed(channelDuty) |-> $past(applyHit) || $past(applyHit, 2))
    else $error("duty changed without apply");
  sampleHalt_a: assert property (srReg == 8'h00 && $past(srReg) == 8'h00 |-> !audioSample)
    else $error("sampling with zero divisor");
endmodule // led_ctl_checker
bind led_driver_control_registers led_ctl_checker chk (.clock(clock), .reset(reset), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
  .audioSample(audioSample), .upperPinOut(upperPinOut), .upperPinOe(upperPinOe), .channelDuty(channelDuty),
  .channelSinkEn(channelSinkEn), .currentScaleQ2(currentScaleQ2), .irq_n(irq_n));

// file: test/host_model.sv
// host side model issuing single byte register accesses
`timescale 1ns/1ps
module host_model (
  input wire clock,
  input wire [7:0] regReadData,
  output reg regWrite,
  output reg regRead,
  output reg [7:0] regAddr,
  output reg [7:0] regWriteData
);
  initial begin
    {regWrite, regRead, regAddr, regWriteData} = 18'h00000;
  end
  // host advances the address itself, one strobe per byte
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      #1 regWrite = 1'b1;
      regAddr = a;
      regWriteData = d;
      @(posedge clock);
      #1 regWrite = 1'b0;
      regAddr = ~a;
      regWriteData = ~d;
    end
  endtask
  // apart from reset, reading the state register is the only way to clear the interrupt
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clock);
      #1 regRead = 1'b1;
      regAddr = a;
      @(posedge clock);
      #1 regRead = 1'b0;
      regAddr = ~a;
      @(posedge clock);
      #1 d = regReadData;
    end
  endtask
endmodule // host_model

// file: test/tb.sv
// self-checking bench for the led control bank
`timescale 1ns/1ps
module tb;
  localparam [31:0] SCALES = 32'h56781234;
  localparam integer SAMPLE_CYCLES = 40000000 / 15625;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [7:0] upperPinIn = 8'h00;
  reg [7:0] audioLevel = 8'h00;
  reg [7:0] rdv;
  reg [127:0] expDuty;
  integer gap;
  integer fails = 0;
  integer n_checks = 0;
  integer i;
  wire regWrite, regRead, audioSample, irq_n;
  wire [7:0] regAddr, regWriteData, regReadData, upperPinOut, upperPinOe;
  wire [127:0] channelDuty;
  wire [15:0] channelOn, channelSinkEn;
  wire [3:0] currentScaleQ2;
  initial begin
    forever #12.5 clock = ~clock;
  end
  host_model host (.clock(clock), .regReadData(regReadData), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData));
  led_driver_control_registers DUT (.clock(clock), .reset(reset), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData), .audioLevel(audioLevel),
    .audioSample(audioSample), .upperPinIn(upperPinIn), .upperPinOut(upperPinOut), .upperPinOe(upperPinOe),
    .channelDuty(channelDuty), .channelOn(channelOn), .channelSinkEn(channelSinkEn),
    .currentScaleQ2(currentScaleQ2), .irq_n(irq_n));
  task check(input [63:0] what, input [127:0] seen, input [127:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        $display("unexpected %0s expected %0h seen %0h", what, exp, seen);
        fails = fails + 1;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  // pin synchroniser delays the change by a few cycles
  task waitIrqLow;
    integer k;
    begin
      k = 0;
      while (irq_n !== 1'b0 && k < 20) begin
        tick(1);
        k = k + 1;
      end
      if (irq_n !== 1'b0) begin
        fails = fails + 1;
        tally_and_finish;
      end
    end
  endtask
  // sample pulse stands one cycle; cnt is the distance in cycles from the previous pulse
  task waitSample(output integer cnt);
    begin
      cnt = 1;
      tick(1);
      while (audioSample !== 1'b1 && cnt < 6000) begin
        tick(1);
        cnt = cnt + 1;
      end
      if (audioSample !== 1'b1) begin
        fails = fails + 1;
        tally_and_finish;
      end
    end
  endtask
  initial begin
    repeat (50000) @(posedge clock);
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    tick(5);
    reset = 1'b0;
    tick(2);
    check("irq", irq_n, 1'b1);
    check("sink", channelSinkEn, 16'hFFFF);
    check("on", channelOn, 16'hFFFF);
    check("oe", upperPinOe, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      host.wr(8'h03, {1'h0, i[2:0], 4'h0});
      tick(2);
      check("scale", currentScaleQ2, SCALES[4 * i +: 4]);
    end
    host.wr(8'h10, 8'h55);
    host.wr(8'h1F, 8'hAA);
    tick(2);
    check("duty", channelDuty, 128'h0);
    host.wr(8'hB0, 8'h01);
    tick(2);
    check("duty", channelDuty, 128'h0);
    host.wr(8'hB0, 8'h00);
    tick(2);
    check("duty", channelDuty, {8'h55, 112'h0, 8'hAA});
    check("duty16", channelDuty[127:120], 8'h55);
    host.wr(8'h02, 8'h5A);
    tick(2);
    check("on", channelOn, 16'hFF5A);
    host.wr(8'h04, 8'hFF);
    host.wr(8'h05, 8'h0F);
    host.wr(8'h06, 8'hA5);
    tick(2);
    check("oe", upperPinOe, 8'hF0);
    check("pinOut", upperPinOut, 8'hA5);
    check("sink", channelSinkEn, 16'h00FF);
    upperPinIn = 8'h01;
    waitIrqLow;
    check("irq", irq_n, 1'b0);
    tick(3);
    host.rd(8'h08, rdv);
    check("state", rdv, 8'h01);
    check("irq", irq_n, 1'b1);
    host.wr(8'h07, 8'h01);
    tick(1);
    upperPinIn = 8'h00;
    tick(10);
    check("irqMask", irq_n, 1'b1);
    upperPinIn = 8'h02;
    waitIrqLow;
    check("irq", irq_n, 1'b0);
    tick(3);
    host.rd(8'h08, rdv);
    check("state", rdv, 8'h02);
    host.rd(8'h05, rdv);
    check("other", rdv, 8'h00);
    host.wr(8'hC0, 8'h33);
    tick(2);
    check("oe", upperPinOe, 8'hF0);
    // frame 8: on bytes at 9Eh and 9Fh, duty bytes A0h..AFh serve channel 16 down to 1
    host.wr(8'h9E, 8'hC3);
    host.wr(8'h9F, 8'h3C);
    for (i = 0; i < 16; i = i + 1) begin
      host.wr(8'hA0 + i[7:0], 8'h40 + i[7:0]);
      expDuty[(15 - i) * 8 +: 8] = 8'h40 + i[7:0];
    end
    host.wr(8'hB7, 8'hE0);
    host.wr(8'h00, 8'h20);
    tick(40);
    check("autoOn", channelOn, 16'hC33C);
    check("autoDuty", channelDuty, expDuty);
    // frame delay is far beyond the run length, so auto play holds frame 8 until the bench switches to audio mode
    audioLevel = 8'hFF;
    host.wr(8'h09, 8'h02);
    host.wr(8'h00, 8'h40);
    waitSample(gap);
    waitSample(gap);
    check("rate", gap, 2 * SAMPLE_CYCLES);
    check("audioOn", channelOn, 16'hC33C);
    check("audDuty", channelDuty, expDuty);
    tally_and_finish;
  end
endmodule // tb
